//--- pp_pkg.sv
// constants, modes and state layout of the multi-mode parallel port
// assumes a 10 MHz system clock and an internal i/o decode on one clock
`default_nettype none
package pp_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TIMEOUT_MS = 10;
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned TCNT_W = 24;
  // ==========================================================
  // buffering
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FWD_W = 9;
  // ==========================================================
  // offsets, first base
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_CTRL = 3'h2;
  localparam logic [2:0] OFS_EPP_ADDR = 3'h3;
  // offsets, second base
  localparam logic [2:0] OFS_FIFO = 3'h0;
  localparam logic [2:0] OFS_CNFG_B = 3'h1;
  localparam logic [2:0] OFS_EXT = 3'h2;
  // ==========================================================
  // control fields
  localparam int unsigned CTL_STROBE = 0;
  localparam int unsigned CTL_AUTOFD = 1;
  localparam int unsigned CTL_INIT = 2;
  localparam int unsigned CTL_SELIN = 3;
  localparam int unsigned CTL_IRQEN = 4;
  localparam int unsigned CTL_DIR = 5;
  localparam int unsigned ST_TIMEOUT = 0;
  localparam logic [1:0] CTL_RSVD = 2'h3;
  localparam logic [1:0] STAT_RSVD = 2'h3;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] CNFG_A = 8'h10;
  localparam logic [7:0] CNFG_B = 8'h00;
  localparam logic [7:0] UNMAPPED = 8'hff;
  // ==========================================================
  // extended-control modes
  localparam logic [2:0] MODE_SPP = 3'h0;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;
  // ==========================================================
  // states and carriers
  typedef enum logic [1:0] {E_IDLE, E_STROBE, E_TAIL} epp_st_t;
  typedef enum logic [1:0] {F_IDLE, F_STROBE, F_WAITLOW} fwd_st_t;
  typedef enum logic [0:0] {R_IDLE, R_ACKED} rev_st_t;
  typedef struct packed {
    logic ack_n;
    logic busy;
    logic pe;
    logic slct;
    logic err_n;
    logic [7:0] pd;
  } pins_in_t;
  typedef struct packed {
    pins_in_t s1;
    pins_in_t s2;
    logic ack_prev;
    logic epp;
    logic [5:0] ctl;
    logic [7:0] data;
    logic [7:0] ext_ctl;
    logic cycle_timeout_flag;
    logic irq;
    epp_st_t est;
    logic est_write;
    logic est_addr;
    logic [TCNT_W-1:0] tcnt;
    fwd_st_t fst;
    logic [7:0] fbyte;
    logic ftag;
    rev_st_t rvs;
    logic [6:0] rle_cnt;
    logic rle_pend;
    logic [7:0] rep_byte;
    logic [7:0] rep_left;
    logic [7:0] rdata;
    logic done;
    logic wait_stretch;
    logic [7:0] pd_out;
    logic pd_oe;
    logic strobe_n;
    logic autofd_n;
    logic init_n;
    logic selin_n;
  } pp_st_t;
endpackage
`default_nettype wire

//--- parallel_port_epp_ecp.sv
// multi-mode parallel port: standard control, enhanced handshake, fifo modes
// assumes an i/o decode on clk giving one-cycle read/write pulses per access
// What this block does
// RULE1: control register reads its top two bits as ones.
// RULE2: direction bit five low drives data lines, high receives them; outside enhanced mode, modes 000 and 010 always drive.
// RULE3: with bit four set, acknowledge rising edge raises an interrupt.
// RULE4: control bit three drives select-in pin inverted.
// RULE5: control bit two drives init pin directly; zero initialises.
// RULE6: control bit one drives auto-feed pin inverted.
// RULE7: control bit zero drives strobe pin inverted.
// RULE8: enhanced offset three starts address write or read cycles.
// RULE9: enhanced offsets four to seven start data write or read cycles.
// RULE10: outside enhanced offsets, pins follow the control register; modes 010 and 011 drive strobe by handshake, 011 also select-in and feed.
// RULE11: wait lasting ten milliseconds aborts cycle and sets timeout flag.
// RULE12: software clears control bits zero, one, three before enhanced cycles.
// RULE13: hardware drives strobe, feed and select-in during enhanced cycles.
// RULE14: address write drives byte, asserts write and address strobes.
// RULE15: wait release ends strobe and bus cycle; wait return ends write.
// RULE16: address read floats lines, latches on wait release.
// RULE17: data write drives byte, asserts write and data strobes.
// RULE18: data read floats lines, latches on wait release.
// RULE19: sixteen-byte fifo per direction in extended modes.
// RULE20: run-length bytes are expanded; no compression.
// RULE21: second-base offset zero decodes by mode.
// RULE22: timeout flag clears by reset or writing one; reads one outside enhanced.
// RULE23: timeout counts clocks from cycle start, stops at wait release.
// RULE24: abort returns strobes inactive and completes the host cycle.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// fifo, power-of-two depth
module pp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_t;
  fifo_st_t q, d;

  // extra pointer bit tells full from empty
  assign in_ready = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
  assign out_valid = (q.wp != q.rp);
  assign out_data = q.mem[q.rp[AW-1:0]];

  // push and pop
  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'h1;
    end
    if (out_valid && out_ready) begin
      d.rp = q.rp + 1'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // pp_fifo

// ============================================================
// port top
module parallel_port_epp_ecp #(
  parameter int unsigned TIMEOUT_CYCLES = pp_pkg::TIMEOUT_CYC,
  parameter int unsigned FIFO_DEPTH = pp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic epp_mode,
  input wire logic internal_io_write,
  input wire logic internal_io_read,
  input wire logic io_base2,
  input wire logic [2:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_done,
  output logic bus_wait_stretch,
  input wire logic [7:0] printer_data_in,
  output logic [7:0] printer_data_lines,
  output logic printer_data_oe,
  output logic strobe_pin,
  output logic auto_feed_pin,
  output logic init_pin,
  output logic select_in_pin,
  input wire logic ack_n_pin,
  input wire logic busy_pin,
  input wire logic perror_pin,
  input wire logic select_pin,
  input wire logic fault_n_pin,
  output logic irq
);
  localparam logic [pp_pkg::TCNT_W-1:0] TO_LAST = pp_pkg::TCNT_W'(TIMEOUT_CYCLES - 1);

  pp_pkg::pp_st_t st_q, d;
  logic [2:0] mode, mode_n;
  logic dir, dir_n, epp_hit, rv_ok;
  logic fw_push, fw_ready, fw_valid, fw_pop;
  logic [pp_pkg::FWD_W-1:0] fw_wdata, fw_out;
  logic rv_push, rv_ready, rv_valid, rv_pop;
  logic [7:0] rv_wdata, rv_out;

  // direction forced forward outside enhanced mode in standard mode 000 and fifo mode 010
  function automatic logic dir_of(input logic [5:0] c, input logic [2:0] m, input logic e);
    dir_of = c[pp_pkg::CTL_DIR] && (e || !(m == pp_pkg::MODE_SPP || m == pp_pkg::MODE_FIFO));
  endfunction

  // ==========================================================
  // buffers, one per direction
  pp_fifo #(.WIDTH(pp_pkg::FWD_W), .DEPTH(FIFO_DEPTH)) u_fwd ( // RULE19
    .clk(clk), .rst(rst), .in_valid(fw_push), .in_data(fw_wdata), .in_ready(fw_ready),
    .out_valid(fw_valid), .out_data(fw_out), .out_ready(fw_pop));
  pp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rev ( // RULE19
    .clk(clk), .rst(rst), .in_valid(rv_push), .in_data(rv_wdata), .in_ready(rv_ready),
    .out_valid(rv_valid), .out_data(rv_out), .out_ready(rv_pop));

  // ==========================================================
  // next state
  always_comb begin
    d = st_q;
    fw_push = 1'h0;
    fw_wdata = '0;
    fw_pop = 1'h0;
    rv_push = 1'h0;
    rv_wdata = 8'h00;
    rv_pop = 1'h0;
    mode = st_q.ext_ctl[7:5];
    dir = dir_of(st_q.ctl, mode, st_q.epp);
    epp_hit = st_q.epp && !io_base2 && (io_addr >= pp_pkg::OFS_EPP_ADDR);
    rv_ok = (mode == pp_pkg::MODE_ECP) && dir && (st_q.rep_left == 8'h00) && rv_ready;
    // pins pass two flops before use
    d.s1 = {ack_n_pin, busy_pin, perror_pin, select_pin, fault_n_pin, printer_data_in};
    d.s2 = st_q.s1;
    d.ack_prev = st_q.s2.ack_n;
    d.epp = epp_mode;
    d.done = 1'h0;
    d.irq = st_q.ctl[pp_pkg::CTL_IRQEN] && st_q.s2.ack_n && !st_q.ack_prev; // RULE3
    // enhanced handshake; wait input rides on the busy pin
    case (st_q.est)
      pp_pkg::E_STROBE: begin
        d.tcnt = st_q.tcnt + 1'h1; // RULE23
        if (st_q.s2.busy) begin
          if (!st_q.est_write) begin
            d.rdata = st_q.s2.pd; // RULE16 RULE18
          end
          d.done = 1'h1; // RULE15
          d.wait_stretch = 1'h0;
          d.tcnt = '0;
          d.est = st_q.est_write ? pp_pkg::E_TAIL : pp_pkg::E_IDLE;
        end else if (st_q.tcnt == TO_LAST) begin
          d.cycle_timeout_flag = 1'h1; // RULE11
          d.done = 1'h1; // RULE24
          d.wait_stretch = 1'h0;
          d.est = pp_pkg::E_IDLE;
        end
      end
      pp_pkg::E_TAIL: begin
        // write strobe held until wait returns; bounded by the same count
        d.tcnt = st_q.tcnt + 1'h1;
        if (!st_q.s2.busy || st_q.tcnt == TO_LAST) begin
          d.est = pp_pkg::E_IDLE; // RULE15
        end
      end
      default: ;
    endcase
    // host writes
    if (internal_io_write && st_q.est != pp_pkg::E_STROBE) begin
      d.done = !epp_hit;
      if (epp_hit) begin
        d.data = io_wdata; // RULE8 RULE9
        d.est = pp_pkg::E_STROBE;
        d.est_write = 1'h1;
        d.est_addr = (io_addr == pp_pkg::OFS_EPP_ADDR);
        d.tcnt = '0; // RULE23
        d.wait_stretch = 1'h1;
      end else if (!io_base2) begin
        case (io_addr)
          pp_pkg::OFS_DATA: begin
            if (mode == pp_pkg::MODE_ECP) begin
              fw_push = 1'h1;
              fw_wdata = {1'h1, io_wdata};
            end else begin
              d.data = io_wdata;
            end
          end
          pp_pkg::OFS_STATUS: begin
            if (io_wdata[pp_pkg::ST_TIMEOUT]) begin
              d.cycle_timeout_flag = 1'h0; // RULE22
            end
          end
          pp_pkg::OFS_CTRL: d.ctl = io_wdata[5:0];
          default: ;
        endcase
      end else begin
        case (io_addr)
          pp_pkg::OFS_FIFO: begin
            if (mode == pp_pkg::MODE_FIFO || mode == pp_pkg::MODE_ECP ||
                mode == pp_pkg::MODE_TEST) begin
              fw_push = 1'h1; // RULE21
              fw_wdata = {1'h0, io_wdata};
            end
          end
          pp_pkg::OFS_EXT: d.ext_ctl = {io_wdata[7:2], 2'h0};
          default: ;
        endcase
      end
    end
    // host reads
    if (internal_io_read && st_q.est != pp_pkg::E_STROBE) begin
      d.done = !epp_hit;
      d.rdata = pp_pkg::UNMAPPED;
      if (epp_hit) begin
        d.est = pp_pkg::E_STROBE; // RULE8 RULE9
        d.est_write = 1'h0;
        d.est_addr = (io_addr == pp_pkg::OFS_EPP_ADDR);
        d.tcnt = '0;
        d.wait_stretch = 1'h1;
      end else if (!io_base2) begin
        case (io_addr)
          pp_pkg::OFS_DATA: d.rdata = dir ? st_q.s2.pd : st_q.data;
          pp_pkg::OFS_STATUS: d.rdata = {!st_q.s2.busy, st_q.s2.ack_n, st_q.s2.pe,
            st_q.s2.slct, st_q.s2.err_n, pp_pkg::STAT_RSVD,
            st_q.epp ? st_q.cycle_timeout_flag : 1'h1}; // RULE22
          pp_pkg::OFS_CTRL: d.rdata = {pp_pkg::CTL_RSVD, st_q.ctl}; // RULE1
          default: ;
        endcase
      end else begin
        case (io_addr)
          pp_pkg::OFS_FIFO: begin
            if (mode == pp_pkg::MODE_CFG) begin
              d.rdata = pp_pkg::CNFG_A; // RULE21
            end else if (mode == pp_pkg::MODE_TEST && fw_valid) begin
              fw_pop = 1'h1;
              d.rdata = fw_out[7:0];
            end else if (mode == pp_pkg::MODE_ECP && dir && rv_valid) begin
              rv_pop = 1'h1;
              d.rdata = rv_out;
            end
          end
          pp_pkg::OFS_CNFG_B: begin
            if (mode == pp_pkg::MODE_CFG) begin
              d.rdata = pp_pkg::CNFG_B;
            end
          end
          pp_pkg::OFS_EXT: d.rdata = {st_q.ext_ctl[7:2],
            dir ? !rv_ready : !fw_ready, dir ? !rv_valid : !fw_valid};
          default: ;
        endcase
      end
    end
    // forward drain to the peripheral
    case (st_q.fst)
      pp_pkg::F_IDLE: begin
        if ((mode == pp_pkg::MODE_FIFO || mode == pp_pkg::MODE_ECP) && !dir && fw_valid) begin
          fw_pop = 1'h1;
          d.fbyte = fw_out[7:0];
          d.ftag = fw_out[8];
          d.fst = pp_pkg::F_STROBE;
        end
      end
      pp_pkg::F_STROBE: if (st_q.s2.busy) d.fst = pp_pkg::F_WAITLOW;
      pp_pkg::F_WAITLOW: if (!st_q.s2.busy) d.fst = pp_pkg::F_IDLE;
      default: d.fst = pp_pkg::F_IDLE;
    endcase
    // reverse capture; a command byte below 80h is a run count
    case (st_q.rvs)
      pp_pkg::R_IDLE: begin
        if (rv_ok && !st_q.s2.ack_n) begin
          d.rvs = pp_pkg::R_ACKED;
          if (!st_q.s2.busy) begin
            if (!st_q.s2.pd[7]) begin
              d.rle_cnt = st_q.s2.pd[6:0]; // RULE20
              d.rle_pend = 1'h1;
            end
          end else if (st_q.rle_pend) begin
            d.rep_byte = st_q.s2.pd;
            d.rep_left = {1'h0, st_q.rle_cnt} + 8'h01;
            d.rle_pend = 1'h0;
          end else begin
            rv_push = 1'h1;
            rv_wdata = st_q.s2.pd;
          end
        end
      end
      pp_pkg::R_ACKED: if (st_q.s2.ack_n) d.rvs = pp_pkg::R_IDLE;
      default: d.rvs = pp_pkg::R_IDLE;
    endcase
    // run expansion stalls on a full buffer
    if (st_q.rep_left != 8'h00 && rv_ready) begin
      rv_push = 1'h1; // RULE20
      rv_wdata = st_q.rep_byte;
      d.rep_left = st_q.rep_left - 8'h01;
    end
    // pins from the new state
    mode_n = d.ext_ctl[7:5];
    dir_n = dir_of(d.ctl, mode_n, d.epp);
    d.strobe_n = !d.ctl[pp_pkg::CTL_STROBE]; // RULE7 RULE10
    d.autofd_n = !d.ctl[pp_pkg::CTL_AUTOFD]; // RULE6
    d.init_n = d.ctl[pp_pkg::CTL_INIT]; // RULE5
    d.selin_n = !d.ctl[pp_pkg::CTL_SELIN]; // RULE4
    d.pd_out = d.data;
    d.pd_oe = !dir_n; // RULE2
    if (d.est != pp_pkg::E_IDLE) begin
      d.strobe_n = !d.est_write; // RULE13 RULE14 RULE17
      d.selin_n = !(d.est == pp_pkg::E_STROBE && d.est_addr);
      d.autofd_n = !(d.est == pp_pkg::E_STROBE && !d.est_addr);
      d.pd_oe = d.est_write; // RULE16 RULE18
    end else if (mode_n == pp_pkg::MODE_FIFO || mode_n == pp_pkg::MODE_ECP) begin
      if (d.fst != pp_pkg::F_IDLE) begin
        d.pd_out = d.fbyte;
        d.strobe_n = (d.fst != pp_pkg::F_STROBE);
      end
      if (mode_n == pp_pkg::MODE_ECP) begin
        d.selin_n = 1'h1;
        d.autofd_n = dir_n ? !(d.rvs == pp_pkg::R_IDLE && d.rep_left == 8'h00) : !d.ftag;
      end
    end
  end

  // state register; pins come up idle with init asserted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.ctl <= pp_pkg::CTL_RESET;
      st_q.ext_ctl <= pp_pkg::EXT_RESET;
      st_q.strobe_n <= 1'h1;
      st_q.autofd_n <= 1'h1;
      st_q.selin_n <= 1'h1;
      st_q.pd_oe <= 1'h1;
      st_q.s1.ack_n <= 1'h1; // idle level, so no false edge after reset
      st_q.s2.ack_n <= 1'h1;
      st_q.ack_prev <= 1'h1;
    end else begin
      st_q <= d;
    end
  end

  assign io_rdata = st_q.rdata;
  assign io_done = st_q.done;
  assign bus_wait_stretch = st_q.wait_stretch;
  assign printer_data_lines = st_q.pd_out;
  assign printer_data_oe = st_q.pd_oe;
  assign strobe_pin = st_q.strobe_n;
  assign auto_feed_pin = st_q.autofd_n;
  assign init_pin = st_q.init_n;
  assign select_in_pin = st_q.selin_n;
  assign irq = st_q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_epp_start;
    internal_io_write && st_q.epp && !io_base2 && io_addr == pp_pkg::OFS_EPP_ADDR &&
      st_q.est != pp_pkg::E_STROBE;
  endsequence
  sequence s_strobes_on;
    !select_in_pin && !strobe_pin && bus_wait_stretch && printer_data_oe;
  endsequence

  a_ctl_read_ones: assert property (internal_io_read && !io_base2 && // RULE1
    io_addr == pp_pkg::OFS_CTRL && st_q.est != pp_pkg::E_STROBE
    |=> io_done && io_rdata[7:6] == 2'h3) else $error("control top bits not one");
  a_irq_on_rise: assert property (st_q.ctl[pp_pkg::CTL_IRQEN] && st_q.s2.ack_n && // RULE3
    !st_q.ack_prev |=> irq) else $error("ack rise gave no irq");
  a_init_follows: assert property (init_pin == st_q.ctl[pp_pkg::CTL_INIT]) // RULE5
    else $error("init pin mismatch");
  a_spp_pins: assert property (st_q.est == pp_pkg::E_IDLE && // RULE4 RULE6 RULE7 RULE10
    st_q.ext_ctl[7:6] == 2'h0 |-> strobe_pin == !st_q.ctl[0] &&
    auto_feed_pin == !st_q.ctl[1] && select_in_pin == !st_q.ctl[3])
    else $error("standard pins mismatch");
  a_dir_input: assert property (st_q.est == pp_pkg::E_IDLE && st_q.epp && // RULE2
    st_q.ctl[pp_pkg::CTL_DIR] |-> !printer_data_oe) else $error("drove in input dir");
  a_addr_write: assert property (s_epp_start |=> s_strobes_on) // RULE8 RULE14
    else $error("address write strobes missing");
  a_wait_release: assert property (st_q.est == pp_pkg::E_STROBE && st_q.s2.busy // RULE15
    |=> io_done && !bus_wait_stretch && select_in_pin && auto_feed_pin)
    else $error("wait release not honoured");
  a_read_latch: assert property (st_q.est == pp_pkg::E_STROBE && !st_q.est_write && // RULE18
    st_q.s2.busy |=> io_rdata == $past(st_q.s2.pd)) else $error("read data not latched");
  a_timeout_abort: assert property (st_q.est == pp_pkg::E_STROBE && !st_q.s2.busy && // RULE11
    st_q.tcnt == TO_LAST |=> st_q.cycle_timeout_flag && io_done && strobe_pin &&
    auto_feed_pin && select_in_pin) else $error("timeout abort wrong"); // RULE24
  a_flag_reads_one: assert property (internal_io_read && !st_q.epp && !io_base2 && // RULE22
    io_addr == pp_pkg::OFS_STATUS |=> io_rdata[0]) else $error("flag not one");
  a_rle_repeat: assert property (st_q.rep_left != 8'h00 && rv_ready // RULE20
    |=> st_q.rep_left == $past(st_q.rep_left) - 8'h01) else $error("run not expanded");
endmodule // parallel_port_epp_ecp
`default_nettype wire

//--- pp_periph_model.sv
// peripheral model for the enhanced address/data handshake
// assumes strobes are registered on clk and busy is synced inside the port
`timescale 1ns/1ps
`default_nettype none
module pp_periph_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic [3:0] dly,
  input wire logic [7:0] rd_byte,
  input wire logic address_strobe_n_n,
  input wire logic data_strobe_n_n,
  output logic busy_pin,
  output logic [7:0] pd
);
  // ==========================================================
  // answer a strobe with the byte after dly clocks and busy one clock later; stall leaves it hanging
  initial begin
    busy_pin = 1'b0;
    pd = 8'h00;
    forever begin
      @(posedge clk);
      if (!(address_strobe_n_n && data_strobe_n_n) && !stall) begin
        repeat (dly) @(posedge clk);
        pd <= rd_byte;
        @(posedge clk);
        busy_pin <= 1'b1;
        while (!(address_strobe_n_n && data_strobe_n_n)) @(posedge clk);
        // released bus shows the inverse, never a stale byte
        pd <= ~rd_byte;
        busy_pin <= 1'b0;
      end
    end
  end
endmodule // pp_periph_model
`default_nettype wire

//--- test_parallel_port_epp_ecp.sv
// self-checking bench of the multi-mode parallel port
// assumes pp_periph_model answers the enhanced strobes
`timescale 1ns/1ps
`default_nettype none
`define check_eq(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_parallel_port_epp_ecp;
  localparam int unsigned TO_CYC = 20;
  logic clk, rst, epp_mode, wr, rd, base2, stall, w;
  logic [2:0] addr, a;
  logic [7:0] wdata, v, r, rd_byte, io_rdata, pd_out, pd_in, s_pd;
  logic [7:0] exp_q [8];
  logic io_done, bws, oe, stb, afd, ini, sel, ack_n, pe, slct, err_n, busy, irq;
  logic s_stb, s_afd, s_sel, s_oe, s_bws;
  logic [3:0] dly;
  int n_fail = 0, compares = 0, cyc = 0, irq_cnt = 0, seed, i, t0;
  // ==========================================================
  // design and far side
  parallel_port_epp_ecp #(.TIMEOUT_CYCLES(TO_CYC), .FIFO_DEPTH(8)) u_parallel_port_epp_ecp (
    .clk(clk), .rst(rst), .epp_mode(epp_mode), .internal_io_write(wr),
    .internal_io_read(rd), .io_base2(base2), .io_addr(addr), .io_wdata(wdata),
    .io_rdata(io_rdata), .io_done(io_done), .bus_wait_stretch(bws),
    .printer_data_in(pd_in), .printer_data_lines(pd_out), .printer_data_oe(oe),
    .strobe_pin(stb), .auto_feed_pin(afd), .init_pin(ini), .select_in_pin(sel),
    .ack_n_pin(ack_n), .busy_pin(busy), .perror_pin(pe), .select_pin(slct),
    .fault_n_pin(err_n), .irq(irq));
  pp_periph_model u_pp_periph_model (.clk(clk), .stall(stall), .dly(dly),
    .rd_byte(rd_byte), .address_strobe_n_n(sel), .data_strobe_n_n(afd), .busy_pin(busy), .pd(pd_in));
  // ==========================================================
  // clock, hang guard, interrupt pulse count
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one access: pulse at a falling edge, snapshot pins one cycle in
  task automatic io(input logic w_i, input logic b_i, input logic [2:0] a_i,
                    input logic [7:0] d_i, output logic [7:0] q);
    int n;
    wr = w_i;
    rd = !w_i;
    base2 = b_i;
    addr = a_i;
    wdata = d_i;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    {s_stb, s_afd, s_sel, s_oe, s_bws, s_pd} = {stb, afd, sel, oe, bws, pd_out};
    n = 0;
    while (io_done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `check_eq(io_done, 1'b1)
    q = io_rdata;
    @(negedge clk);
  endtask
  // ack low then high; a rising edge may raise irq
  task automatic ack_pulse();
    ack_n = 1'b0;
    repeat (3) @(negedge clk);
    ack_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    seed = 93;
    {rst, epp_mode, wr, rd, base2, stall, addr, wdata} = {6'h20, 3'h0, 8'h00};
    {ack_n, pe, slct, err_n, dly, rd_byte} = {4'h9, 4'h1, 8'h00};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    io(1'b0, 1'b0, 3'h2, 8'h00, r);
    `check_eq(r, 8'hc0)
    `check_eq(ini, 1'b0)
    // mode 001: unlike mode 000, bit five sets the direction of the data lines
    io(1'b1, 1'b1, 3'h2, 8'h20, r);
    // random control bytes, mode 001
    for (i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      io(1'b1, 1'b0, 3'h2, v, r);
      `check_eq(s_stb, ~v[0])
      `check_eq(s_afd, ~v[1])
      `check_eq(s_sel, ~v[3])
      `check_eq(ini, v[2])
      `check_eq(s_oe, ~v[5])
      io(1'b0, 1'b0, 3'h2, 8'h00, r);
      `check_eq(r, {2'h3, v[5:0]})
      io(1'b1, 1'b0, 3'h0, ~v, r);
      if (!v[5]) `check_eq(pd_out, ~v)
    end
    v = 8'($random(seed));
    {pe, slct, err_n} = v[2:0];
    repeat (4) @(negedge clk);
    io(1'b0, 1'b0, 3'h1, 8'h00, r);
    `check_eq(r[6:0], {ack_n, pe, slct, err_n, 3'h7})
    io(1'b1, 1'b0, 3'h2, 8'h14, r);
    t0 = irq_cnt;
    ack_pulse();
    `check_eq(irq_cnt - t0, 1)
    io(1'b1, 1'b0, 3'h2, 8'h04, r);
    t0 = irq_cnt;
    ack_pulse();
    `check_eq(irq_cnt - t0, 0)
    // enhanced mode: pins still follow control off the enhanced offsets
    epp_mode = 1'b1;
    repeat (2) @(negedge clk);
    io(1'b1, 1'b0, 3'h2, 8'h07, r);
    `check_eq({s_stb, s_afd}, 2'h0)
    io(1'b1, 1'b0, 3'h2, 8'h04, r);
    for (i = 0; i < 10; i++) begin
      a = 3'h3 + 3'(i >> 1);
      w = i[0];
      v = 8'($random(seed));
      dly = {1'b0, v[6:4]};
      rd_byte = v;
      io(w, 1'b0, a, v, r);
      `check_eq(s_bws, 1'b1)
      `check_eq(s_stb, ~w)
      `check_eq(s_sel, a != 3'h3)
      `check_eq(s_afd, a == 3'h3)
      `check_eq(s_oe, w)
      if (w) `check_eq(s_pd, v)
      else `check_eq(r, v)
      repeat (12) @(negedge clk);
      `check_eq({stb, sel, afd}, 3'h7)
    end
    // peripheral never answers: abort after the timeout count
    stall = 1'b1;
    t0 = cyc;
    io(1'b1, 1'b0, 3'h3, 8'h3c, r);
    // abort count plus the request edge and the task's trailing edge
    `check_eq(cyc - t0, TO_CYC + 2)
    `check_eq({stb, sel, afd}, 3'h7)
    io(1'b0, 1'b0, 3'h1, 8'h00, r);
    `check_eq(r[0], 1'b1)
    io(1'b1, 1'b0, 3'h1, 8'h01, r);
    io(1'b0, 1'b0, 3'h1, 8'h00, r);
    `check_eq(r[0], 1'b0)
    stall = 1'b0;
    // test fifo: fill past full, drain past empty
    epp_mode = 1'b0;
    io(1'b1, 1'b1, 3'h2, 8'hc0, r);
    io(1'b0, 1'b1, 3'h2, 8'h00, r);
    `check_eq(r[1:0], 2'h1)
    for (i = 0; i < 9; i++) begin
      v = 8'($random(seed));
      if (i < 8) exp_q[i] = v;
      io(1'b1, 1'b1, 3'h0, v, r);
    end
    io(1'b0, 1'b1, 3'h2, 8'h00, r);
    `check_eq(r[1:0], 2'h2)
    for (i = 0; i < 8; i++) begin
      io(1'b0, 1'b1, 3'h0, 8'h00, r);
      `check_eq(r, exp_q[i])
    end
    io(1'b0, 1'b1, 3'h0, 8'h00, r);
    `check_eq(r, 8'hff)
    io(1'b1, 1'b1, 3'h2, 8'he0, r);
    io(1'b0, 1'b1, 3'h0, 8'h00, r);
    `check_eq(r, 8'h10)
    io(1'b0, 1'b1, 3'h1, 8'h00, r);
    `check_eq(r, 8'h00)
    // fifo mode 010: a pushed byte goes out with the strobe low, no busy reply
    io(1'b1, 1'b1, 3'h2, 8'h40, r);
    io(1'b1, 1'b1, 3'h0, v, r);
    `check_eq({stb, oe, pd_out}, {2'h1, v})
    summarize();
  end
endmodule // test_parallel_port_epp_ecp
`default_nettype wire
